// file: rtl/ilo_pkg.sv
// Package with opcodes, field positions, reset values and shared helpers.
package ilo_pkg;
   localparam int          INSTR_W      = 14;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 7;
   localparam int          OPC_HI       = 13;
   localparam int          OPC_LO       = 8;
   localparam int          DEST_BIT     = 7;
   localparam int          ADDR_HI      = 6;
   localparam int          LIT_HI       = 7;
   localparam logic [5:0]  OPC_INC      = 6'h0A;
   localparam logic [5:0]  OPC_INC_SKIP = 6'h0F;
   localparam logic [5:0]  OPC_OR_LIT   = 6'h38;
   localparam logic        DEST_ACC     = 1'h0;
   localparam logic [7:0]  ACC_RST      = 8'h00;
   localparam logic        ZERO_RST     = 1'h0;
   localparam logic [7:0]  RD_RST       = 8'h00;
   localparam logic [7:0]  ONE8         = 8'h01;

   typedef enum logic [1:0] {OP_NONE, OP_INC, OP_INC_SKIP, OP_OR_LIT} ilo_op_e;
   typedef enum logic {ST_RUN, ST_FLUSH} ilo_state_e;

   typedef struct packed {
      ilo_state_e        state;
      logic [7:0]        acc;
      logic              zflag;
      logic              retire;
      logic              discard;
      logic              unknown;
      logic [7:0]        rd_data;
   } ilo_core_s;

   // Wrapping 8-bit increment.
   function automatic logic [7:0] ilo_inc8(input logic [7:0] v);
      return 8'(v + ONE8);
   endfunction

   function automatic logic ilo_is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction
endpackage

// file: rtl/ilo_alu_if.sv
// Interface between the core state holder and the instruction decoder.
`timescale 1ns/1ns
interface ilo_alu_if;
   import ilo_pkg::*;
   logic [13:0] instr;
   logic [7:0]  fval;
   logic [7:0]  acc;
   ilo_op_e     op;
   logic        dest;
   logic [6:0]  addr;
   logic [7:0]  result;
   logic        zero;

   modport dec  (input instr, fval, acc, output op, dest, addr, result, zero);
   modport core (output instr, fval, acc, input op, dest, addr, result, zero);
endinterface

// file: rtl/ilo_decode.sv
// Combinational decoder and arithmetic for the three supported instructions.
`timescale 1ns/1ns
module ilo_decode
   import ilo_pkg::*;
(
   ilo_alu_if.dec bus
);
   always_comb begin
      bus.dest   = bus.instr[DEST_BIT];
      bus.addr   = bus.instr[ADDR_HI:0];
      bus.op     = OP_NONE;
      bus.result = bus.acc;
      unique case (bus.instr[OPC_HI:OPC_LO])
         OPC_INC: begin
            bus.op     = OP_INC;
            bus.result = ilo_inc8(bus.fval);
         end
         OPC_INC_SKIP: begin
            bus.op     = OP_INC_SKIP;
            bus.result = ilo_inc8(bus.fval);
         end
         OPC_OR_LIT: begin
            bus.op     = OP_OR_LIT;
            bus.result = bus.acc | bus.instr[LIT_HI:0];
         end
         default: begin
            bus.op     = OP_NONE;
         end
      endcase
      bus.zero = ilo_is_zero(bus.result);
   end
endmodule

// file: rtl/ilo_core.sv
// Execute stage for increment, increment-and-skip and OR-literal instructions.
// Summary of operation
// - Decode increment_file, add one to register.
// - Destination bit picks accumulator or file register.
// - Increment updates zero flag, one cycle.
// - Skip variant keeps flags, discards next if zero.
// - Decode or_literal_into_accumulator, OR literal with accumulator.
// - OR result to accumulator, zero flag, one cycle.
`timescale 1ns/1ns
module ilo_core
   import ilo_pkg::*;
#(
   parameter int DEPTH = 128
)
(
   // Clock and reset.
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   // Instruction issue.
   input  wire logic              instr_valid,
   input  wire logic [13:0]       instr_word,
   // File register load and read-back from the rest of the core.
   input  wire logic              load_valid,
   input  wire logic [6:0]        load_addr,
   input  wire logic [7:0]        load_data,
   input  wire logic [6:0]        rd_addr,
   output logic      [7:0]        rd_data,
   // Architectural state and status.
   output logic      [7:0]        acc_out,
   output logic                   zero_flag,
   output logic                   flush_pending,
   output logic                   retire,
   output logic                   discard,
   output logic                   unknown_op
);
   ilo_alu_if  bus ();
   ilo_core_s  st_r;
   ilo_core_s  st_nxt;
   logic [7:0] file_mem [DEPTH];
   logic       exec;
   logic       file_wr;

   ilo_decode u_decode (
      .bus (bus)
   );

   assign bus.instr = instr_word;
   assign bus.fval  = file_mem[bus.addr];
   assign bus.acc   = st_r.acc;

   // An instruction executes only when issued outside a skip flush.
   assign exec    = instr_valid && (st_r.state == ST_RUN);
   assign file_wr = exec && (bus.op == OP_INC || bus.op == OP_INC_SKIP)
                    && (bus.dest != DEST_ACC);

   always_comb begin
      st_nxt         = st_r;
      st_nxt.retire  = 1'b0;
      st_nxt.discard = 1'b0;
      st_nxt.unknown = 1'b0;
      st_nxt.rd_data = file_mem[rd_addr];
      unique case (st_r.state)
         ST_RUN: begin
            if (instr_valid) begin
               st_nxt.retire  = bus.op != OP_NONE;
               st_nxt.unknown = bus.op == OP_NONE;
               unique case (bus.op)
                  OP_INC: begin
                     if (bus.dest == DEST_ACC) begin
                        st_nxt.acc = bus.result;
                     end
                     st_nxt.zflag = bus.zero;
                  end
                  OP_INC_SKIP: begin
                     if (bus.dest == DEST_ACC) begin
                        st_nxt.acc = bus.result;
                     end
                     if (bus.zero) begin
                        st_nxt.state = ST_FLUSH;
                     end
                  end
                  OP_OR_LIT: begin
                     st_nxt.acc   = bus.result;
                     st_nxt.zflag = bus.zero;
                  end
                  OP_NONE: begin
                  end
               endcase
            end
         end
         ST_FLUSH: begin
            // The already fetched word is replaced by a no_operation.
            if (instr_valid) begin
               st_nxt.discard = 1'b1;
               st_nxt.state   = ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         st_r.state   <= ST_RUN;
         st_r.acc     <= ACC_RST;
         st_r.zflag   <= ZERO_RST;
         st_r.retire  <= 1'b0;
         st_r.discard <= 1'b0;
         st_r.unknown <= 1'b0;
         st_r.rd_data <= RD_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Write-back from an executing instruction wins over an external load.
   always_ff @(posedge ref_clk) begin
      if (file_wr) begin
         file_mem[bus.addr] <= bus.result;
      end else if (load_valid) begin
         file_mem[load_addr] <= load_data;
      end
   end

   assign rd_data       = st_r.rd_data;
   assign acc_out       = st_r.acc;
   assign zero_flag     = st_r.zflag;
   assign flush_pending = st_r.state == ST_FLUSH;
   assign retire        = st_r.retire;
   assign discard       = st_r.discard;
   assign unknown_op    = st_r.unknown;

   // Assertions sample on the core clock and stand down while reset is low.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   AST_INC_TO_FILE: assert property (
      exec && bus.op == OP_INC && bus.dest
      |=> file_mem[$past(bus.addr)] == 8'($past(bus.fval) + ONE8))
      else $error("Increment to file did not store value plus one.");

   AST_INC_TO_ACC: assert property (
      exec && (bus.op == OP_INC || bus.op == OP_INC_SKIP) && !bus.dest
          && !(load_valid && load_addr == bus.addr)
      |=> acc_out == 8'($past(bus.fval) + ONE8)
          && file_mem[$past(bus.addr)] == $past(bus.fval))
      else $error("Increment with accumulator destination misrouted.");

   AST_INC_ZERO: assert property (
      exec && bus.op == OP_INC
      |=> retire && zero_flag == ($past(bus.fval) == 8'hFF))
      else $error("Increment zero flag or completion wrong.");

   AST_SKIP_KEEPS_FLAG: assert property (
      exec && bus.op == OP_INC_SKIP |=> zero_flag == $past(zero_flag))
      else $error("Skip increment altered the zero flag.");

   AST_SKIP_DISCARD: assert property (
      exec && bus.op == OP_INC_SKIP && bus.fval == 8'hFF
      ##1 instr_valid |=> discard && !flush_pending && !retire)
      else $error("Word after zero skip result was not discarded.");

   AST_NO_SKIP: assert property (
      exec && bus.op == OP_INC_SKIP && bus.fval != 8'hFF |=> !flush_pending)
      else $error("Skip taken on nonzero result.");

   AST_OR_ACC: assert property (
      exec && bus.op == OP_OR_LIT
      |=> acc_out == ($past(acc_out) | $past(instr_word[LIT_HI:0])))
      else $error("OR literal result wrong.");

   AST_OR_ZERO: assert property (
      exec && bus.op == OP_OR_LIT |=> retire && zero_flag == (acc_out == 8'h00))
      else $error("OR literal zero flag or completion wrong.");

   AST_WRAP: assert property (
      exec && bus.op == OP_INC && !bus.dest && bus.fval == 8'hFF
      |=> acc_out == 8'h00 && zero_flag)
      else $error("Increment did not wrap to zero.");

   AST_INC_FILE_KEEPS_ACC: assert property (
      exec && (bus.op == OP_INC || bus.op == OP_INC_SKIP) && bus.dest
      |=> acc_out == $past(acc_out))
      else $error("Increment with file destination touched the accumulator.");

   AST_SKIP_TO_FILE: assert property (
      exec && bus.op == OP_INC_SKIP && bus.dest
      |=> file_mem[$past(bus.addr)] == 8'($past(bus.fval) + ONE8))
      else $error("Skip increment to file did not store value plus one.");

   AST_SKIP_RETIRES: assert property (
      exec && bus.op == OP_INC_SKIP && bus.fval == 8'hFF
      |=> retire && flush_pending && !discard)
      else $error("Zero skip result did not retire and arm the flush.");

   AST_SKIP_ACC_ZERO: assert property (
      exec && bus.op == OP_INC_SKIP && !bus.dest && bus.fval == 8'hFF
      |=> acc_out == 8'h00 && flush_pending)
      else $error("Skip increment to accumulator did not wrap and arm the flush.");

   AST_FLUSH_HOLDS: assert property (
      flush_pending && !instr_valid |=> flush_pending && !discard)
      else $error("Flush was lost during an idle cycle.");

   // A discarded word must leave the accumulator, zero flag and addressed file register alone.
   AST_FLUSH_NO_EFFECT: assert property (
      flush_pending && instr_valid && !(load_valid && load_addr == bus.addr)
      |=> acc_out == $past(acc_out) && zero_flag == $past(zero_flag)
          && file_mem[$past(bus.addr)] == $past(bus.fval))
      else $error("Discarded word changed accumulator, flag or file register.");

   AST_DISCARD_PULSE: assert property (
      discard |-> (!flush_pending && !retire && !unknown_op) ##1 !discard)
      else $error("Discard pulse longer than one cycle or overlapping.");

   AST_UNKNOWN_NOP: assert property (
      exec && bus.op == OP_NONE
      |=> unknown_op && !retire && acc_out == $past(acc_out)
          && zero_flag == $past(zero_flag))
      else $error("Unsupported opcode changed state or retired.");

   // Main scenarios: wrap to zero, taken skip, zero after OR, file destination.
   COV_INC_WRAP:  cover property (exec && bus.op == OP_INC && bus.fval == 8'hFF);
   COV_SKIP:      cover property (exec && bus.op == OP_INC_SKIP ##1 instr_valid ##1 discard);
   COV_OR_ZERO:   cover property (exec && bus.op == OP_OR_LIT ##1 zero_flag);
   COV_INC_FILE:  cover property (exec && bus.op == OP_INC && bus.dest);
   COV_SKIP_ACC:  cover property (exec && bus.op == OP_INC_SKIP && !bus.dest ##1 flush_pending);
endmodule

// file: bench/test_increment_and_or_literal_ops.sv
// Self-checking testbench comparing the execute block against an integer model.
`timescale 1ns/1ns
module test_increment_and_or_literal_ops;
   import ilo_pkg::*;
   logic        ref_clk     = 1'b0;
   logic        rst_b       = 1'b0;
   logic        instr_valid = 1'b0;
   logic [13:0] instr_word  = 14'h0000;
   logic        load_valid  = 1'b0;
   logic [6:0]  load_addr   = 7'h00;
   logic [7:0]  load_data   = 8'h00;
   logic [6:0]  rd_addr     = 7'h00;
   logic [7:0]  rd_data;
   logic [7:0]  acc_out;
   logic        zero_flag;
   logic        flush_pending;
   logic        retire;
   logic        discard;
   logic        unknown_op;
   int          mem [128];
   int          acc;
   int          zf;
   int          fl;
   int          mismatches;
   int          tests_run;
   int          kind;
   int          a;
   int          w;

   ilo_core ilo_core_inst (
      .ref_clk       (ref_clk),
      .rst_b         (rst_b),
      .instr_valid   (instr_valid),
      .instr_word    (instr_word),
      .load_valid    (load_valid),
      .load_addr     (load_addr),
      .load_data     (load_data),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .acc_out       (acc_out),
      .zero_flag     (zero_flag),
      .flush_pending (flush_pending),
      .retire        (retire),
      .discard       (discard),
      .unknown_op    (unknown_op)
   );

   always #25 ref_clk = ~ref_clk;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // The load strobe is left high so back-to-back loads never toggle it in one step.
   task automatic load(input int fa, input int d);
      instr_valid = 1'b0;
      load_valid = 1'b1;
      load_addr = 7'(fa);
      load_data = 8'(d);
      mem[fa] = d;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic exec(input logic [13:0] iw);
      int op, fa, r, er, ed, eu;
      op = int'(iw[13:8]);
      fa = int'(iw[6:0]);
      er = 0;
      ed = 0;
      eu = 0;
      if (fl != 0) begin
         ed = 1;
         fl = 0;
      end else if (op == OPC_INC || op == OPC_INC_SKIP) begin
         r = (mem[fa] + 1) % 256;
         er = 1;
         if (iw[7] == DEST_ACC) acc = r;
         else mem[fa] = r;
         if (op == OPC_INC) zf = int'(r == 0);
         else fl = int'(r == 0);
      end else if (op == OPC_OR_LIT) begin
         acc = acc | int'(iw[7:0]);
         zf = int'(acc == 0);
         er = 1;
      end else eu = 1;
      load_valid = 1'b0;
      instr_valid = 1'b1;
      instr_word = iw;
      @(posedge ref_clk);
      #1;
      chk(8'(retire), 8'(er));
      chk(8'(discard), 8'(ed));
      chk(8'(unknown_op), 8'(eu));
      chk(acc_out, 8'(acc));
      chk(8'(zero_flag), 8'(zf));
      chk(8'(flush_pending), 8'(fl));
   endtask

   task automatic idle(input bit readback, input int fa);
      instr_valid = 1'b0;
      load_valid = 1'b0;
      rd_addr = 7'(fa);
      repeat (readback ? 2 : 1) @(posedge ref_clk);
      #1;
      chk(8'(flush_pending), 8'(fl));
      if (readback) chk(rd_data, 8'(mem[fa]));
   endtask

   initial begin
      #(50 * 20000);
      mismatches++;
      end_sim();
   end

   initial begin
      void'($urandom(57));
      repeat (10) @(posedge ref_clk);
      #1;
      chk(acc_out, ACC_RST);
      chk(8'(zero_flag), 8'(ZERO_RST));
      rst_b = 1'b1;
      for (int i = 0; i < 9; i++) load((i == 8) ? 127 : i, (i < 3) ? 8'hFF : $urandom % 256);
      for (int i = 0; i < 500; i++) begin
         kind = $urandom % 10;
         a = $urandom % 9;
         a = (a == 8) ? 127 : a;
         w = ($urandom % 2) * 128 + a;
         if (i % 15 == 0) load(a, ($urandom % 2 == 0) ? 8'hFF : 8'hFE);
         if (kind < 3) exec(14'({OPC_INC, 8'h00}) | 14'(w));
         else if (kind < 5) exec(14'({OPC_INC_SKIP, 8'h00}) | 14'(w));
         else if (kind < 7) exec(14'({OPC_OR_LIT, 8'h00}) | 14'(($urandom % 3 == 0) ? 0 : w));
         else if (kind == 7) begin
            w = $urandom % 64;
            if (w == OPC_INC || w == OPC_INC_SKIP || w == OPC_OR_LIT) w = 0;
            exec(14'(w * 256 + ($urandom % 256)));
         end else idle(kind == 9, a);
      end
      // A reset in mid-run clears accumulator, flag and flush but keeps the file.
      exec({OPC_OR_LIT, 8'h00});
      load(0, 8'hFF);
      exec({OPC_INC_SKIP, 8'h80});
      rst_b = 1'b0;
      acc = 0;
      zf = 0;
      fl = 0;
      idle(1'b0, 0);
      chk(acc_out, ACC_RST);
      chk(8'(zero_flag), 8'(ZERO_RST));
      chk(8'(retire), 8'h00);
      rst_b = 1'b1;
      exec({OPC_OR_LIT, 8'h00});
      for (int i = 0; i < 9; i++) idle(1'b1, (i == 8) ? 127 : i);
      end_sim();
   end
endmodule
